// File: src/mcs_top.sv
// Conversion control and serial port of the multichannel converter.
`timescale 1ns/100ps
module mcs_top #(
   parameter int CONV_CYCLES = mcs_pkg::CONVERSION_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_conversion_start,
   input wire logic i_reset_pin,
   input wire logic i_power_down_in,
   input wire logic [127:0] i_channel_data,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic i_din,
   output logic o_sdo,
   output logic o_sdo_oe,
   output logic o_busy_or_second_data_out,
   output logic o_busy,
   output logic [15:0] o_cfg_active
);
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] sync3;
   mcs_pkg::mcs_state_t state;
   mcs_pkg::mcs_state_t next_state;
   logic [15:0] conv_cnt;
   logic [15:0] cfg_active;
   logic [15:0] conv_cfg;
   logic [15:0] readback_cfg;
   logic [15:0] pend_word;
   logic pend_valid;
   logic [2:0] wr_sync;
   logic [1:0] undef_cnt;
   logic sdo_block;
   logic [15:0] result [mcs_pkg::NUM_CHANNELS];
   logic [4:0] rise_cnt;
   logic [15:0] din_sr;
   logic wr_tog;
   logic [7:0] bit_idx;

   // The start, reset and power-down pins pass two flip-flops; the third stage only feeds edge detection.
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         sync3 <= 3'h0;
      end else begin
         sync1 <= {i_power_down_in, i_reset_pin, i_conversion_start};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   wire start_rise = sync2[0] & ~sync3[0];
   wire reset_level = sync2[1];
   wire reset_rise = sync2[1] & ~sync3[1];
   wire pd_level = sync2[2];
   wire pd_rise = sync2[2] & ~sync3[2];
   wire pd_fall = ~sync2[2] & sync3[2];
   wire abort = reset_level | pd_level;
   wire [1:0] chan_field = cfg_active[mcs_pkg::CHAN_FIELD_HI:mcs_pkg::CHAN_FIELD_LO];
   wire [3:0] start_channels = {1'b0, chan_field, 1'b0} + 4'h2;
   wire start = (state == mcs_pkg::MCS_IDLE) & start_rise & ~abort;
   wire eoc = (state == mcs_pkg::MCS_CONVERT) & (conv_cnt == 16'h0000) & ~abort;
   wire word_arrived = wr_sync[1] ^ wr_sync[2];
   wire arrived_updates = din_sr[mcs_pkg::CFG_UPDATE_BIT];

   // Conversion timing scales with the number of channels enabled at the start.
   wire [15:0] conv_load = 16'(CONV_CYCLES * start_channels) - 16'h0001;

   always_comb begin
      next_state = state;
      unique case (state)
         mcs_pkg::MCS_IDLE: begin
            if (start) begin
               next_state = mcs_pkg::MCS_CONVERT;
            end
         end
         mcs_pkg::MCS_CONVERT: begin
            if (abort || eoc) begin
               next_state = mcs_pkg::MCS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= mcs_pkg::MCS_IDLE;
         conv_cnt <= 16'h0000;
         o_busy <= 1'b0;
      end else begin
         state <= next_state;
         o_busy <= (next_state == mcs_pkg::MCS_CONVERT);
         if (start) begin
            conv_cnt <= conv_load;
         end else if (conv_cnt != 16'h0000) begin
            conv_cnt <= conv_cnt - 16'h0001;
         end
      end
   end

   // The written word is only ever handed over at an end of conversion, so the
   // analog settings never change in the middle of a conversion.
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_sync <= 3'h0;
         pend_valid <= 1'b0;
         pend_word <= mcs_pkg::CFG_DEFAULT;
      end else begin
         wr_sync <= {wr_sync[1:0], wr_tog};
         if (reset_level) begin
            pend_valid <= 1'b0;
         end else if (word_arrived) begin
            pend_valid <= arrived_updates;
            pend_word <= din_sr;
         end else if (eoc) begin
            pend_valid <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg_active <= mcs_pkg::CFG_DEFAULT;
         conv_cfg <= mcs_pkg::CFG_DEFAULT;
         readback_cfg <= mcs_pkg::CFG_DEFAULT;
         o_cfg_active <= mcs_pkg::CFG_DEFAULT;
      end else begin
         if (reset_level) begin
            cfg_active <= mcs_pkg::CFG_DEFAULT;
            conv_cfg <= mcs_pkg::CFG_DEFAULT;
            readback_cfg <= mcs_pkg::CFG_DEFAULT;
         end else begin
            if (eoc && pend_valid) begin
               cfg_active <= pend_word;
            end
            if (start) begin
               conv_cfg <= cfg_active;
            end
            if (eoc) begin
               readback_cfg <= conv_cfg;
            end
         end
         o_cfg_active <= cfg_active;
      end
   end

   // Power-down leaves the front end unsettled, so two results are forced invalid.
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         undef_cnt <= 2'h0;
         sdo_block <= 1'b0;
      end else begin
         if (pd_fall) begin
            undef_cnt <= mcs_pkg::UNDEF_CONVERSIONS;
         end else if (eoc && undef_cnt != 2'h0) begin
            undef_cnt <= undef_cnt - 2'h1;
         end
         if (reset_rise || pd_rise || abort) begin
            sdo_block <= 1'b1;
         end else if (eoc) begin
            sdo_block <= 1'b0;
         end
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < mcs_pkg::NUM_CHANNELS; ch++) begin : g_result
         always_ff @(posedge i_clock or negedge i_arst_n) begin
            if (!i_arst_n) begin
               result[ch] <= mcs_pkg::RESULT_CLEARED;
            end else if (reset_level) begin
               result[ch] <= mcs_pkg::RESULT_CLEARED;
            end else if (eoc) begin
               result[ch] <= (undef_cnt != 2'h0) ? mcs_pkg::RESULT_CLEARED :
                  i_channel_data[ch*16 +: 16];
            end
         end
      end
   endgenerate

   // Serial clock domain. Chip select high clears the counters, so a partial
   // word never raises the hand-over toggle.
   always_ff @(posedge i_sclk or posedge i_cs_n or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rise_cnt <= 5'h00;
      end else if (i_cs_n) begin
         rise_cnt <= 5'h00;
      end else if (rise_cnt != 5'h10) begin
         rise_cnt <= rise_cnt + 5'h01;
      end
   end

   // The shift word is left alone by chip select so the system side can still
   // copy it after the toggle crosses, even if chip select rises at once.
   always_ff @(posedge i_sclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         din_sr <= mcs_pkg::CFG_DEFAULT;
         wr_tog <= 1'b0;
      end else if (!i_cs_n && rise_cnt != 5'h10) begin
         din_sr <= {din_sr[14:0], i_din};
         if (rise_cnt == 5'h0f) begin
            wr_tog <= ~wr_tog;
         end
      end
   end

   always_ff @(negedge i_sclk or posedge i_cs_n or negedge i_arst_n) begin
      if (!i_arst_n) begin
         bit_idx <= 8'h00;
      end else if (i_cs_n) begin
         bit_idx <= 8'h00;
      end else if (bit_idx != mcs_pkg::LAST_BIT_INDEX) begin
         bit_idx <= bit_idx + 8'h01;
      end
   end

   // Result and readback words change only at end of conversion or on reset, when the host
   // keeps the port quiet, so the shifter reads them as held values.
   wire [1:0] rd_field = readback_cfg[mcs_pkg::CHAN_FIELD_HI:mcs_pkg::CHAN_FIELD_LO];
   wire [3:0] rd_channels = {1'b0, rd_field, 1'b0} + 4'h2;
   wire [3:0] rd_half = {2'b00, rd_field} + 4'h1;
   wire dual = ~readback_cfg[mcs_pkg::READOUT_BIT];
   wire [3:0] word_sel = bit_idx[7:4];
   wire [3:0] bit_sel = 4'hf - bit_idx[3:0];
   wire [3:0] main_words = dual ? rd_half : rd_channels;
   wire [3:0] upper_sel = word_sel + rd_half;
   wire [2:0] main_ch = word_sel[2:0];
   wire [2:0] upper_ch = upper_sel[2:0];
   wire main_bit = (word_sel < main_words) ? result[main_ch][bit_sel] :
      (word_sel == main_words) ? readback_cfg[bit_sel] : 1'b0;
   wire upper_bit = (word_sel < rd_half) ? result[upper_ch][bit_sel] : 1'b0;

   assign o_sdo = main_bit;
   assign o_sdo_oe = ~i_cs_n & ~sdo_block;
   assign o_busy_or_second_data_out = i_cs_n ? o_busy :
      (dual ? upper_bit : 1'b0);
endmodule : mcs_top

// File: include/mcs_pkg.sv
// Constants, encodings and states shared by the converter control block.
// Behaviour
// - Start-input rising edge begins one conversion of all currently enabled channels.
// - Start-input edges are ignored while a conversion is still running.
// - Busy is high during conversion; its fall marks end of conversion.
// - An unread result is overwritten at the following end of conversion.
// - A configuration word unfinished at end of conversion is latched at the one after.
// - Word shifted in after one end of conversion is latched at the next.
// - New configuration steers conversions only after one start/end pair.
// - Results are readable right after the conversion that made them.
// - Reset or power-down rising edge aborts conversion and floats data output.
// - Reset clears stored results so early readback returns invalid data.
// - First two results after leaving power-down are undefined.
// - Result MSB appears on the outputs as soon as chip select falls.
// - Output enabled by chip select low; bits advance on clock falling edges.
// - Configuration bit 0 selects whether busy pin becomes a second data output.
// - Serial clock may idle high or low between transfers.
// - Single output sends each enabled channel, 16 bits, MSB first, upward.
// - With chip select high the shared pin shows busy.
// - Dual readout puts lower channels on main output, upper on second.
// - After results, 16 more clocks read back this conversion's configuration.
// - Reset loads the all-ones default configuration.
// - Channel-count field bits 14:13 select 2, 4, 6 or 8 channels.
package mcs_pkg;
   localparam int WORD_BITS = 16;
   localparam int NUM_CHANNELS = 8;
   localparam logic [15:0] CFG_DEFAULT = 16'hffff;
   localparam int CFG_UPDATE_BIT = 15;
   localparam int CHAN_FIELD_HI = 14;
   localparam int CHAN_FIELD_LO = 13;
   localparam int READOUT_BIT = 0;
   localparam int CLOCK_MHZ = 50;
   localparam int CONVERSION_TIME_NS = 1000;
   localparam int CONVERSION_CYCLES = (CONVERSION_TIME_NS * CLOCK_MHZ + 999) / 1000;
   localparam logic [1:0] UNDEF_CONVERSIONS = 2'h2;
   localparam logic [7:0] LAST_BIT_INDEX = 8'h90;
   localparam logic [15:0] RESULT_CLEARED = 16'h0000;
   typedef enum logic [1:0] {
      MCS_IDLE = 2'b01,
      MCS_CONVERT = 2'b10
   } mcs_state_t;
endpackage : mcs_pkg

// File: tb/mcs_chk.sv
// Port assertions for the converter control block.
`timescale 1ns/100ps
module mcs_chk #(
   parameter int CONV_CYCLES = 5
) (
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_conversion_start,
   input wire logic i_reset_pin,
   input wire logic i_power_down_in,
   input wire logic i_cs_n,
   input wire logic o_sdo_oe,
   input wire logic o_busy_or_second_data_out,
   input wire logic o_busy,
   input wire logic [15:0] o_cfg_active
);
   int cnt;
   logic [1:0] code;
   // The channel code is frozen while busy, so a late cfg copy cannot skew the count.
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt <= 0;
         code <= 2'h3;
      end else begin
         cnt <= o_busy ? cnt + 1 : 0;
         code <= o_busy ? code : o_cfg_active[14:13];
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   chk_oe_cs: assert property (o_sdo_oe |-> !i_cs_n)
      else $error("sdo driven while cs high");
   chk_pin_busy: assert property (i_cs_n |-> o_busy_or_second_data_out == o_busy)
      else $error("shared pin differs from busy");
   chk_conv_len: assert property (disable iff (!i_arst_n || i_reset_pin || i_power_down_in)
      $fell(o_busy) |-> cnt == CONV_CYCLES * 2 * (code + 1)) else $error("conversion length");
   chk_busy_cause: assert property ($rose(o_busy) |-> $past(i_conversion_start, 2))
      else $error("busy without start");
   chk_cfg_hold: assert property (disable iff (!i_arst_n || i_reset_pin || i_power_down_in)
      o_busy && $past(o_busy) |-> $stable(o_cfg_active)) else $error("cfg changed in conversion");
   chk_sdo_block: assert property ($past(i_reset_pin, 4) || $past(i_power_down_in, 4) |-> !o_sdo_oe)
      else $error("sdo enabled after reset or power down");
   chk_abort_busy: assert property ((i_reset_pin || i_power_down_in) [*5] |=> !o_busy)
      else $error("conversion not aborted");
   chk_cfg_dflt: assert property (!$past(i_arst_n) |-> o_cfg_active == mcs_pkg::CFG_DEFAULT)
      else $error("cfg not default after reset");
endmodule : mcs_chk
bind mcs_top mcs_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.i_clock(i_clock), .i_arst_n(i_arst_n),
   .i_conversion_start(i_conversion_start), .i_reset_pin(i_reset_pin),
   .i_power_down_in(i_power_down_in), .i_cs_n(i_cs_n), .o_sdo_oe(o_sdo_oe),
   .o_busy_or_second_data_out(o_busy_or_second_data_out), .o_busy(o_busy),
   .o_cfg_active(o_cfg_active));

// File: tb/mcs_host.sv
// Serial master model standing on the far side of the four-wire port.
`timescale 1ns/100ps
module mcs_host (
   output logic o_cs_n,
   output logic o_sclk,
   output logic o_din,
   input wire logic i_sdo,
   input wire logic i_oe,
   input wire logic i_second_serial_output
);
   logic [0:159] cap1;
   logic [0:159] cap2;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_din = 1'b0;
   end
   // The clock stands still between frames; a released data line flips so stale bits never pass.
   task xfer(input int nb, input logic [15:0] w, input logic ih);
      o_sclk = ih;
      // A new idle level must settle while chip select is still high, or its edge races the select.
      #10;
      o_cs_n = 1'b0;
      #30;
      for (int i = 0; i < nb; i++) begin
         o_din = w[15 - i % 16];
         cap1[i] = i_oe ? i_sdo : 1'bx;
         cap2[i] = i_second_serial_output;
         o_sclk = !ih;
         #40;
         o_sclk = ih;
         #40;
      end
      #30;
      o_cs_n = 1'b1;
      o_din = !o_din;
   endtask : xfer
endmodule : mcs_host

// File: tb/test_multichannel_adc_conversion_serial_port.sv
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
module test_multichannel_adc_conversion_serial_port;
   logic i_clock = 1'b0;
   logic i_arst_n = 1'b0;
   logic start = 1'b0;
   logic rst_pin = 1'b0;
   logic pd = 1'b0;
   logic pv = 1'b0;
   logic [127:0] data = 128'h0;
   logic cs_n, sclk, din, sdo, oe, pin2, busy;
   logic [15:0] cfg, cur, used, pend, w;
   logic [15:0] d [0:7];
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 90518;
   int zc = 0;
   always #10 i_clock = ~i_clock;
   mcs_top #(.CONV_CYCLES(5)) DUT (.i_clock(i_clock), .i_arst_n(i_arst_n),
      .i_conversion_start(start), .i_reset_pin(rst_pin), .i_power_down_in(pd),
      .i_channel_data(data), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .o_sdo(sdo),
      .o_sdo_oe(oe), .o_busy_or_second_data_out(pin2), .o_busy(busy), .o_cfg_active(cfg));
   mcs_host host (.o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_sdo(sdo), .i_oe(oe),
      .i_second_serial_output(pin2));
   task cmp_word(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp_word
   task close_out;
      if (errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out
   task tick(input int n);
      repeat (n) @(posedge i_clock);
      #2;
   endtask : tick
   task conv(input logic again);
      used = cur;
      for (int k = 0; k < 8; k++) begin
         d[k] = 16'($random(seed));
         data[16 * k +: 16] = d[k];
      end
      start = 1'b1;
      tick(6);
      start = 1'b0;
      if (again) begin
         tick(3);
         start = 1'b1;
         tick(4);
         start = 1'b0;
      end
      for (int k = 0; k < 500 && busy !== 1'b0; k++) tick(1);
      cmp_word({15'h0, busy}, 16'h0);
      for (int k = 0; k < 8; k++) d[k] = zc > 0 ? 16'h0 : d[k];
      zc = zc > 0 ? zc - 1 : 0;
      cur = pv ? pend : cur;
      pv = 1'b0;
   endtask : conv
   task rd(input int nb, input logic [15:0] wd, input logic ih);
      int n;
      logic [15:0] e1;
      logic [15:0] e2;
      n = 2 * (used[14:13] + 1);
      tick(2);
      cmp_word(cfg, cur);
      host.xfer(nb, wd, ih);
      for (int k = 0; k < nb / 16; k++) begin
         e1 = k < n ? d[k] : k == n ? used : 16'h0;
         e2 = 16'h0;
         if (!used[0]) begin
            e1 = k < n / 2 ? d[k] : k == n / 2 ? used : 16'h0;
            e2 = k < n / 2 ? d[n / 2 + k] : 16'h0;
         end
         cmp_word(host.cap1[16 * k +: 16], e1);
         cmp_word(host.cap2[16 * k +: 16], e2);
      end
      if (nb >= 16 && wd[15]) begin
         pend = wd;
         pv = 1'b1;
      end
   endtask : rd
   initial begin
      cur = 16'hffff;
      used = 16'hffff;
      for (int k = 0; k < 8; k++) d[k] = 16'h0;
      tick(4);
      i_arst_n = 1'b1;
      tick(4);
      cmp_word(cfg, 16'hffff);
      rd(144, 16'h7fff, 1'b0);
      conv(1'b0);
      conv(1'b1);
      rd(144, 16'h0, 1'b1);
      for (int j = 0; j < 9; j++) begin
         w = 16'($random(seed));
         w[14:13] = 2'(j);
         w[0] = j[2];
         w[15] = j < 8;
         conv(1'b0);
         rd(144, w, j[0]);
      end
      rd(10, 16'h8000, 1'b0);
      conv(1'b0);
      conv(1'b0);
      start = 1'b1;
      tick(6);
      start = 1'b0;
      rst_pin = 1'b1;
      tick(8);
      cmp_word({15'h0, busy}, 16'h0);
      cmp_word(cfg, 16'hffff);
      rst_pin = 1'b0;
      host.xfer(16, 16'h0, 1'b0);
      cmp_word(host.cap1[0 +: 16], 16'hxxxx);
      cur = 16'hffff;
      pv = 1'b0;
      tick(8);
      for (int j = 0; j < 4; j++) begin
         if (j == 1) begin
            pd = 1'b1;
            tick(8);
            pd = 1'b0;
            zc = 2;
            tick(8);
         end
         conv(1'b0);
         rd(144, 16'h0, j[0]);
      end
      close_out();
   end
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         close_out();
      end
   end
endmodule : test_multichannel_adc_conversion_serial_port
